// [core/twda_pkg.sv]
// constants, types and field layout for the table walk descriptor address block
// Function
// - 16KB level zero is stage 1 only: base[pa-1:4], input bit 47, three zeros.
// - 16KB stage 1 level one: x is 31 minus offset if start, else 14.
// - 16KB stage 2 select 2 starts at level one, x is 31 minus offset.
// - 16KB stage 1 level two: x is 42 minus offset if start, else 14.
// - 16KB stage 2 level two: select 1 gives 42 minus offset, select 2 gives 14.
// - 16KB level three: stage 1 x is 53 minus offset if start, else 14; stage 2 select 0 gives 53 minus offset.
// - start level select 0 means level three, 1 level two, 2 level one.
// - 64KB stage 1 level one: x is 25 minus offset, index from bit 42.
// - 64KB stage 2 select 2 starts at level one, x is 25 minus offset.
// - 64KB stage 1 level two: x is 38 minus offset if start, else 16.
// - 64KB stage 2 level two: select 1 gives 38 minus offset, select 2 gives 16.
// - 64KB stage 1 level three: x is 51 minus offset if start, else 16.
// - 64KB stage 2 level three: select 0 gives 51 minus offset, else 16.
// - a transaction that selects a context runs a one or two stage walk.
// - stage 2 descriptor bits 63 to 60 hold only the allocate overrides.
// - write override: 00 keep, 01 reserved, 10 allocate, 11 no allocate.
// - read override: 00 keep, 01 reserved, 10 allocate, 11 no allocate.
// - override values 10 and 11 replace the transaction's allocation hint.
// - no legacy domain field is checked or applied.
// - first level uses the context table base, later levels the previous descriptor.
// - base slice top is set by the physical address width parameter.
// - start level select applies only to stage 2; stage 1 uses size offset.
package twda_pkg;
	localparam int unsigned TWDA_PA_W      = 48;
	localparam int unsigned TWDA_DESC_W    = 64;
	// register offsets (byte addresses)
	localparam logic [7:0] TWDA_REG_CTRL   = 8'h00;
	localparam logic [7:0] TWDA_REG_S1TB   = 8'h04;
	localparam logic [7:0] TWDA_REG_S2TB   = 8'h08;
	localparam logic [7:0] TWDA_REG_STAT   = 8'h0c;
	localparam logic [7:0] TWDA_REG_ADDR   = 8'h10;
	localparam logic [7:0] TWDA_REG_HINT   = 8'h14;
	// control field positions
	localparam int unsigned TWDA_C_S1OFF   = 0;
	localparam int unsigned TWDA_C_S2OFF   = 8;
	localparam int unsigned TWDA_C_SLSEL   = 16;
	localparam int unsigned TWDA_C_GRAN64  = 18;
	localparam int unsigned TWDA_C_S1EN    = 19;
	localparam int unsigned TWDA_C_S2EN    = 20;
	localparam int unsigned TWDA_C_CTXEN   = 21;
	localparam logic [31:0] TWDA_CTRL_RST  = 32'h0000_0000;
	// granule index offsets, x floors and slice positions
	localparam logic [6:0] TWDA_X16        = 7'h0e;
	localparam logic [6:0] TWDA_X64        = 7'h10;
	localparam logic [6:0] TWDA_K16_L1     = 7'h1f;
	localparam logic [6:0] TWDA_K16_L2     = 7'h2a;
	localparam logic [6:0] TWDA_K16_L3     = 7'h35;
	localparam logic [6:0] TWDA_K64_L1     = 7'h19;
	localparam logic [6:0] TWDA_K64_L2     = 7'h26;
	localparam logic [6:0] TWDA_K64_L3     = 7'h33;
	localparam logic [6:0] TWDA_S16_L3     = 7'h22;
	localparam logic [6:0] TWDA_S16_L2     = 7'h1b;
	localparam logic [6:0] TWDA_S64_L2     = 7'h15;
	localparam logic [6:0] TWDA_S64_L3     = 7'h22;
	localparam int unsigned TWDA_L0_BIT    = 47;
	// stage 1 start thresholds (16KB: l1 17..27, l2 28..38; 64KB: l2 22..34, l3 35..63)
	localparam logic [5:0] TWDA_T16_L2     = 6'h1c;
	localparam logic [5:0] TWDA_T16_L3     = 6'h27;
	localparam logic [5:0] TWDA_T16_L1     = 6'h11;
	localparam logic [5:0] TWDA_T64_L2     = 6'h16;
	localparam logic [5:0] TWDA_T64_L3     = 6'h23;
	// start level select encodings
	localparam logic [1:0] TWDA_SL_L3      = 2'h0;
	localparam logic [1:0] TWDA_SL_L2      = 2'h1;
	localparam logic [1:0] TWDA_SL_L1      = 2'h2;
	// allocate override encodings
	localparam logic [1:0] TWDA_OV_KEEP    = 2'h0;
	localparam logic [1:0] TWDA_OV_RSVD    = 2'h1;
	localparam logic [1:0] TWDA_OV_ALLOC   = 2'h2;
	localparam logic [1:0] TWDA_OV_NOALLOC = 2'h3;
	localparam int unsigned TWDA_WA_HI     = 63;
	localparam int unsigned TWDA_RA_HI     = 61;
	typedef enum logic [3:0] {
		TWDA_IDLE  = 4'b0001,
		TWDA_FETCH = 4'b0010,
		TWDA_WAIT  = 4'b0100,
		TWDA_DONE  = 4'b1000
	} twda_state_t;
endpackage

// [core/twda_walker.sv]
// table walk descriptor address generator with wishbone control registers
`timescale 1ns/1ps
module twda_walker import twda_pkg::*; #(
	parameter int unsigned PA_W = TWDA_PA_W
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        txn_valid_i,
	input  wire logic [47:0] input_addr_i,
	input  wire logic        txn_walloc_i,
	input  wire logic        txn_ralloc_i,
	output logic             txn_ready_o,
	output logic             mem_req_o,
	output logic [63:0]      mem_addr_o,
	input  wire logic        mem_ack_i,
	input  wire logic [63:0] mem_data_i,
	output logic             done_o,
	output logic             walloc_o,
	output logic             ralloc_o
);
	typedef struct packed {
		twda_state_t  st;
		logic [31:0]  ctrl;
		logic [31:0]  s1tb;
		logic [31:0]  s2tb;
		logic [47:0]  ia;
		logic [47:0]  base;
		logic [1:0]   lvl;
		logic         stg2;
		logic         first;
		logic         wa;
		logic         ra;
		logic         ack;
		logic [31:0]  rdat;
		logic         req;
		logic [63:0]  addr;
		logic         done;
		logic         rdy;
	} twda_s_t;
	twda_s_t q_r, q_nxt;

	logic [5:0]  s1off, s2off, off;
	logic [1:0]  slsel;
	logic        g64;
	logic [6:0]  x;
	logic [47:0] idx;
	logic [47:0] slice;
	logic [63:0] daddr;

	assign s1off = q_r.ctrl[TWDA_C_S1OFF +: 6];
	assign s2off = q_r.ctrl[TWDA_C_S2OFF +: 6];
	assign slsel = q_r.ctrl[TWDA_C_SLSEL +: 2];
	assign g64   = q_r.ctrl[TWDA_C_GRAN64];
	assign off   = q_r.stg2 ? s2off : s1off;

	// starting level of a walk; stage 2 uses the select, stage 1 the offset
	function automatic logic [1:0] start_lvl(input logic s2, input logic gr64,
			input logic [5:0] o, input logic [1:0] sl);
		logic [1:0] r;
		r = 2'd1;
		if (s2) begin
			unique case (sl)
				TWDA_SL_L3: r = 2'd3;
				TWDA_SL_L2: r = 2'd2;
				default:    r = 2'd1;
			endcase
		end else if (gr64) begin
			r = (o >= TWDA_T64_L3) ? 2'd3 : (o >= TWDA_T64_L2) ? 2'd2 : 2'd1;
		end else begin
			r = (o >= TWDA_T16_L3) ? 2'd3 : (o >= TWDA_T16_L2) ? 2'd2 :
				(o >= TWDA_T16_L1) ? 2'd1 : 2'd0;
		end
		return r;
	endfunction

	// x: low bit of the base slice; initial level depends on offset, later on granule
	always_comb begin
		logic [6:0] k;
		logic [6:0] fl;
		k  = TWDA_K16_L1;
		fl = g64 ? TWDA_X64 : TWDA_X16;
		unique case (q_r.lvl)
			2'd1: k = g64 ? TWDA_K64_L1 : TWDA_K16_L1;
			2'd2: k = g64 ? TWDA_K64_L2 : TWDA_K16_L2;
			2'd3: k = g64 ? TWDA_K64_L3 : TWDA_K16_L3;
			default: k = TWDA_K16_L1;
		endcase
		if (q_r.lvl == 2'd0) begin
			x = 7'd4;
		end else if (q_r.first) begin
			x = k - {1'b0, off};
		end else begin
			x = fl;
		end
	end

	// index bits: input_addr[x+span:low] placed at bit 3
	always_comb begin
		logic [6:0] lo;
		lo = TWDA_X16;
		unique case (q_r.lvl)
			2'd0: lo = 7'(TWDA_L0_BIT);
			2'd1: lo = g64 ? TWDA_K64_L1 + 7'd17 : TWDA_K16_L1 + 7'd5;
			2'd2: lo = g64 ? TWDA_K64_L2 - 7'd9 : TWDA_K16_L2 - 7'd17;
			default: lo = g64 ? TWDA_X64 : TWDA_X16;
		endcase
		idx   = q_r.ia >> lo;
		slice = q_r.base >> x;
	end

	// concatenate: base[pa-1:x] : ia[y:lo] : 000, zero extended to 64 bits
	always_comb begin
		logic [47:0] m;
		logic [47:0] sh;
		// index sits in bits x-1..3, so the keep mask must reach up to x, not x-3
		m     = (48'h1 << x) - 48'h1;
		sh    = ((slice << x) & ((48'h1 << PA_W) - 48'h1));
		daddr = {16'h0000, sh | ((idx << 3) & m)};
		daddr[2:0] = 3'b000;
	end

	// next state: bus slave, walk sequencing and allocate overrides
	always_comb begin
		logic [1:0] wov;
		logic [1:0] rov;
		logic [47:0] nb;
		q_nxt          = q_r;
		q_nxt.ack      = 1'b0;
		q_nxt.done     = 1'b0;
		q_nxt.rdy      = 1'b0;
		wov            = mem_data_i[TWDA_WA_HI -: 2];
		rov            = mem_data_i[TWDA_RA_HI -: 2];
		nb             = mem_data_i[47:0] & ~48'h0fff;
		// classic wishbone slave, one wait state then ack
		if (wb_cyc_i && wb_stb_i && !q_r.ack) begin
			q_nxt.ack  = 1'b1;
			q_nxt.rdat = 32'h0000_0000;
			unique case (wb_adr_i)
				TWDA_REG_CTRL: q_nxt.rdat = q_r.ctrl;
				TWDA_REG_S1TB: q_nxt.rdat = q_r.s1tb;
				TWDA_REG_S2TB: q_nxt.rdat = q_r.s2tb;
				TWDA_REG_STAT: q_nxt.rdat = {26'h0, q_r.stg2, q_r.lvl, q_r.st[3:1]};
				TWDA_REG_ADDR: q_nxt.rdat = q_r.addr[31:0];
				TWDA_REG_HINT: q_nxt.rdat = {30'h0, q_r.ra, q_r.wa};
				default:       q_nxt.rdat = 32'h0000_0000;
			endcase
			if (wb_we_i) begin
				for (int b = 0; b < 4; b++) begin
					if (wb_sel_i[b]) begin
						if (wb_adr_i == TWDA_REG_CTRL) q_nxt.ctrl[b*8 +: 8] = wb_dat_i[b*8 +: 8];
						if (wb_adr_i == TWDA_REG_S1TB) q_nxt.s1tb[b*8 +: 8] = wb_dat_i[b*8 +: 8];
						if (wb_adr_i == TWDA_REG_S2TB) q_nxt.s2tb[b*8 +: 8] = wb_dat_i[b*8 +: 8];
					end
				end
			end
		end
		unique case (q_r.st)
			TWDA_IDLE: begin
				if (txn_valid_i && q_r.ctrl[TWDA_C_CTXEN]) begin
					q_nxt.rdy   = 1'b1;
					q_nxt.ia    = input_addr_i;
					q_nxt.wa    = txn_walloc_i;
					q_nxt.ra    = txn_ralloc_i;
					q_nxt.stg2  = !q_r.ctrl[TWDA_C_S1EN];
					q_nxt.first = 1'b1;
					q_nxt.base  = q_r.ctrl[TWDA_C_S1EN] ? {q_r.s1tb, 16'h0000}
						: {q_r.s2tb, 16'h0000};
					q_nxt.lvl   = start_lvl(!q_r.ctrl[TWDA_C_S1EN], g64,
						q_r.ctrl[TWDA_C_S1EN] ? s1off : s2off, slsel);
					q_nxt.st    = TWDA_FETCH;
				end else if (txn_valid_i) begin
					q_nxt.rdy   = 1'b1;
					q_nxt.wa    = txn_walloc_i;
					q_nxt.ra    = txn_ralloc_i;
					q_nxt.st    = TWDA_DONE;
				end
			end
			TWDA_FETCH: begin
				q_nxt.req  = 1'b1;
				q_nxt.addr = daddr;
				q_nxt.st   = TWDA_WAIT;
			end
			TWDA_WAIT: begin
				if (mem_ack_i) begin
					q_nxt.req   = 1'b0;
					q_nxt.first = 1'b0;
					if (q_r.lvl != 2'd3) begin
						q_nxt.lvl  = q_r.lvl + 2'd1;
						q_nxt.base = nb;
						q_nxt.st   = TWDA_FETCH;
					end else begin
						// leaf: stage 2 leaf bits 63:60 carry only overrides, no domain
						if (q_r.stg2) begin
							if (wov == TWDA_OV_ALLOC || wov == TWDA_OV_NOALLOC)
								q_nxt.wa = (wov == TWDA_OV_ALLOC);
							if (rov == TWDA_OV_ALLOC || rov == TWDA_OV_NOALLOC)
								q_nxt.ra = (rov == TWDA_OV_ALLOC);
						end
						if (!q_r.stg2 && q_r.ctrl[TWDA_C_S2EN]) begin
							q_nxt.stg2  = 1'b1;
							q_nxt.first = 1'b1;
							q_nxt.base  = {q_r.s2tb, 16'h0000};
							q_nxt.lvl   = start_lvl(1'b1, g64, s2off, slsel);
							q_nxt.st    = TWDA_FETCH;
						end else begin
							q_nxt.st    = TWDA_DONE;
						end
					end
				end
			end
			TWDA_DONE: begin
				q_nxt.done = 1'b1;
				q_nxt.st   = TWDA_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r      <= '0;
			q_r.st   <= TWDA_IDLE;
			q_r.ctrl <= TWDA_CTRL_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign wb_dat_o    = q_r.rdat;
	assign wb_ack_o    = q_r.ack;
	assign txn_ready_o = q_r.rdy;
	assign mem_req_o   = q_r.req;
	assign mem_addr_o  = q_r.addr;
	assign done_o      = q_r.done;
	assign walloc_o    = q_r.wa;
	assign ralloc_o    = q_r.ra;

	sequence fetch_s;
		q_r.st == TWDA_FETCH;
	endsequence
	sequence req_up_s;
		##1 mem_req_o;
	endsequence

	fetch_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		fetch_s |-> req_up_s) else $error("fetch without request");
	addr_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mem_req_o |-> mem_addr_o[2:0] == 3'b000) else $error("unaligned fetch");
	addr_ext_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mem_req_o |-> mem_addr_o[63:48] == 16'h0000) else $error("not zero extended");
	wa_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_r.st == TWDA_WAIT && mem_ack_i && q_r.stg2 && q_r.lvl == 2'd3
		&& mem_data_i[63:62] == TWDA_OV_NOALLOC) |=> !walloc_o)
		else $error("write override lost");
	ra_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_r.st == TWDA_WAIT && mem_ack_i && q_r.stg2 && q_r.lvl == 2'd3
		&& mem_data_i[61:60] == TWDA_OV_ALLOC) |=> ralloc_o)
		else $error("read override lost");
	keep_hint_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_r.st == TWDA_WAIT && mem_ack_i && mem_data_i[63:62] == TWDA_OV_KEEP)
		|=> $stable(walloc_o)) else $error("hint changed on keep");
	s2_l3_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_r.st == TWDA_FETCH && q_r.stg2 && q_r.first && !g64 && q_r.lvl == 2'd3)
		|-> x == TWDA_K16_L3 - {1'b0, s2off}) else $error("16k l3 x wrong");
	later_x_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_r.st == TWDA_FETCH && !q_r.first && q_r.lvl != 2'd0)
		|-> x == (g64 ? TWDA_X64 : TWDA_X16)) else $error("later level x wrong");
	wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack timing");
endmodule // twda_walker

// [tb/twda_mem_model.sv]
// memory partner that answers descriptor fetches for the walker
`timescale 1ns/1ps
module twda_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [1:0]  lat_i,
	input  wire logic [3:0]  ov_i,
	input  wire logic        mem_req_i,
	input  wire logic [63:0] mem_addr_i,
	output logic             mem_ack_o,
	output logic      [63:0] mem_data_o
);
	logic [1:0] cnt_r;
	logic       gap_r;
	// one answer per request; gap_r waits for the drop so a slow release is not answered twice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r      <= 2'h0;
			gap_r      <= 1'b0;
			mem_ack_o  <= 1'b0;
			mem_data_o <= 64'h5a5a_5a5a_5a5a_5a5a;
		end else if (!mem_ack_o && mem_req_i && !gap_r && cnt_r == lat_i) begin
			mem_ack_o  <= 1'b1;
			gap_r      <= 1'b1;
			cnt_r      <= 2'h0;
			mem_data_o <= {ov_i, 12'h000, mem_addr_i[47:12] + 36'h0_0000_0001, 12'h003};
		end else begin
			// data is only good with the answer, scrambled otherwise
			mem_ack_o  <= 1'b0;
			mem_data_o <= ~mem_data_o;
			cnt_r      <= (mem_req_i && !gap_r) ? cnt_r + 2'h1 : 2'h0;
			if (!mem_req_i)
				gap_r <= 1'b0;
		end
	end
endmodule // twda_mem_model

// [tb/tb.sv]
// self-checking bench for the table walk descriptor address block
`timescale 1ns/1ps
module tb import twda_pkg::*;;
	typedef struct {
		logic        g64;
		logic        s2;
		logic [5:0]  off;
		logic [1:0]  sl;
		int          st;
		logic [47:0] ia;
		logic [3:0]  ov;
		logic [1:0]  hin;
		logic [1:0]  hout;
	} twda_row_t;
	// granule, stage, offset, select, start level, address, overrides, hints in, hints out
	twda_row_t rows [12] = '{
		'{1'h0, 1'h0, 6'h10, 2'h0, 0, 48'h8f3c_5a96_e7b1, 4'h0, 2'h1, 2'h1},
		'{1'h0, 1'h0, 6'h11, 2'h0, 1, 48'h4a5b_6c7d_8e9f, 4'h0, 2'h2, 2'h2},
		'{1'h0, 1'h0, 6'h26, 2'h0, 2, 48'h0000_3fff_c008, 4'ha, 2'h3, 2'h3},
		'{1'h0, 1'h1, 6'h10, 2'h2, 1, 48'hfedc_ba98_7654, 4'he, 2'h2, 2'h1},
		'{1'h0, 1'h1, 6'h18, 2'h1, 2, 48'h0123_4567_89ab, 4'hb, 2'h0, 2'h2},
		'{1'h0, 1'h1, 6'h27, 2'h0, 3, 48'h0000_00ff_ffff, 4'h5, 2'h1, 2'h1},
		'{1'h1, 1'h0, 6'h15, 2'h0, 1, 48'hc3a5_9612_4bd7, 4'h0, 2'h2, 2'h2},
		'{1'h1, 1'h0, 6'h16, 2'h0, 2, 48'h0000_0ffe_2468, 4'h0, 2'h1, 2'h1},
		'{1'h1, 1'h0, 6'h27, 2'h0, 3, 48'h0000_00ab_cdef, 4'h0, 2'h0, 2'h0},
		'{1'h1, 1'h1, 6'h10, 2'h2, 1, 48'hffff_ffff_ffff, 4'h0, 2'h3, 2'h3},
		'{1'h1, 1'h1, 6'h12, 2'h1, 2, 48'h0000_3210_fedc, 4'h3, 2'h3, 2'h2},
		'{1'h1, 1'h1, 6'h1f, 2'h0, 3, 48'h0000_0012_3456, 4'h8, 2'h0, 2'h2}};
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, txn_valid_i;
	logic        txn_walloc_i, txn_ralloc_i, txn_ready_o, mem_req_o, mem_ack_i;
	logic        done_o, walloc_o, ralloc_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, ov_r;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [47:0] input_addr_i;
	logic [63:0] mem_addr_o, mem_data_i;
	logic [1:0]  lat_r, ho;
	logic [63:0] seen [$];
	int          errors, check_count;

	twda_walker i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txn_valid_i(txn_valid_i),
		.input_addr_i(input_addr_i), .txn_walloc_i(txn_walloc_i), .txn_ralloc_i(txn_ralloc_i),
		.txn_ready_o(txn_ready_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
		.mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .done_o(done_o),
		.walloc_o(walloc_o), .ralloc_o(ralloc_o));
	twda_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat_r), .ov_i(ov_r),
		.mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
		.mem_data_o(mem_data_i));

	task automatic end_sim;
		$display("comparisons %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// classic single cycle; held until ack is sampled, then released for a cycle
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// valid held until taken, hints read in the done cycle
	task automatic txn(input logic [47:0] ia, input logic [1:0] h);
		seen.delete();
		@(posedge clk_i);
		txn_valid_i  <= 1'b1;
		input_addr_i <= ia;
		txn_walloc_i <= h[1];
		txn_ralloc_i <= h[0];
		do @(posedge clk_i); while (txn_ready_o !== 1'b1);
		txn_valid_i <= 1'b0;
		do @(posedge clk_i); while (done_o !== 1'b1);
		ho = {walloc_o, ralloc_o};
	endtask
	function automatic logic [31:0] ctrl_of(input twda_row_t r);
		return {10'h000, 1'h1, r.s2, !r.s2, r.g64, r.sl, 2'h0, r.s2 ? r.off : 6'h00,
			2'h0, r.s2 ? 6'h00 : r.off};
	endfunction
	// base above x, index bits from lo placed at bit 3, low three bits zero
	function automatic logic [63:0] exp_addr(input logic [47:0] b, ia, input int x, lo);
		logic [47:0] idx;
		idx = (ia >> lo) & ((48'h1 << (x - 3)) - 48'h1);
		return {16'h0000, (b & ~((48'h1 << x) - 48'h1)) | (idx << 3)};
	endfunction

	// every fetch recorded where it is answered
	always @(posedge clk_i) begin
		if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
			seen.push_back(mem_addr_o);
			check({mem_addr_o[63:48], mem_addr_o[2:0]}, 64'h0);
		end
	end
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// whole run is a few hundred cycles; this margin only catches a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		end_sim();
	end
	initial begin : main
		logic [47:0] b;
		logic [63:0] e;
		int          x;
		rst_i <= 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, txn_valid_i, txn_walloc_i, txn_ralloc_i} <= 6'h00;
		{wb_adr_i, wb_dat_i, input_addr_i} <= 88'h0;
		wb_sel_i <= 4'hf;
		ov_r     <= 4'h0;
		lat_r    <= 2'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_xfer(1'b0, TWDA_REG_CTRL, 32'h0);
		check(rd, 32'h0);
		wb_xfer(1'b1, 8'h3c, 32'hffff_ffff);
		wb_xfer(1'b0, 8'h3c, 32'h0);
		check(rd, 32'h0);
		wb_xfer(1'b1, TWDA_REG_S1TB, 32'h0012_3456);
		wb_xfer(1'b1, TWDA_REG_S2TB, 32'h0000_abcd);
		wb_xfer(1'b0, TWDA_REG_S1TB, 32'h0);
		check(rd, 32'h0012_3456);
		for (int k = 0; k < 12; k++) begin
			wb_xfer(1'b1, TWDA_REG_CTRL, ctrl_of(rows[k]));
			wb_xfer(1'b0, TWDA_REG_CTRL, 32'h0);
			check(rd, ctrl_of(rows[k]));
			ov_r  <= rows[k].ov;
			lat_r <= 2'(k % 4);
			txn(rows[k].ia, rows[k].hin);
			check(64'(seen.size()), 64'(4 - rows[k].st));
			b = rows[k].s2 ? 48'h0000_abcd_0000 : 48'h0012_3456_0000;
			for (int lv = rows[k].st; lv < 4; lv++) begin
				x = rows[k].g64 ? 16 : 14;
				if (lv == rows[k].st)
					x = (rows[k].g64 ? 12 + 13 * lv : 20 + 11 * lv) - int'(rows[k].off);
				if (lv == 0)
					x = 4;
				e = exp_addr(b, rows[k].ia, x, rows[k].g64 ? 55 - 13 * lv : 47 - 11 * lv);
				check(seen[lv - rows[k].st], e);
				b = {e[47:12] + 36'h1, 12'h000};
			end
			check(ho, rows[k].hout);
			wb_xfer(1'b0, TWDA_REG_ADDR, 32'h0);
			check(rd, e[31:0]);
		end
		// reset in mid walk with a slow partner
		wb_xfer(1'b1, TWDA_REG_CTRL, ctrl_of(rows[9]));
		lat_r <= 2'h3;
		txn_valid_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i       <= 1'b1;
		txn_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		check({mem_req_o, done_o, txn_ready_o, wb_ack_o}, 64'h0);
		txn(48'h0000_1234_5678, 2'h2);
		check({ho, 62'(seen.size())}, {2'h2, 62'h0});
		end_sim();
	end
endmodule // tb
